/* File: rtl/dmsa_pkg.sv */
// constants and types for data memory sector addressing
package dmsa_pkg;

  // ****************************************
  // address layout
  // ****************************************
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned OFF_W        = 8;
  localparam int unsigned SEC_W        = 2;
  localparam int unsigned SEC_LSB      = 8;
  localparam int unsigned GP_OFF_W     = 7;
  localparam int unsigned GP_IDX_W     = 9;
  localparam int unsigned GP_DEPTH     = 512;
  localparam logic [7:0]  GP_BASE      = 8'h80;
  localparam logic [7:0]  GP_SECTORS   = 8'h04;
  localparam logic [7:0]  SFR_SECTORS  = 8'h02;
  localparam logic [7:0]  SECTOR_ZERO  = 8'h00;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

  // ****************************************
  // indirect ports and pointer bytes
  // ****************************************
  localparam logic [7:0]  OFF_PORT0    = 8'h00;
  localparam logic [7:0]  OFF_PTR0     = 8'h01;
  localparam logic [7:0]  OFF_PORT1    = 8'h02;
  localparam logic [7:0]  OFF_PTR1L    = 8'h03;
  localparam logic [7:0]  OFF_PTR1S    = 8'h04;
  localparam logic [7:0]  OFF_PORT2    = 8'h0c;
  localparam logic [7:0]  OFF_PTR2L    = 8'h0d;
  localparam logic [7:0]  OFF_PTR2S    = 8'h0e;
  localparam int unsigned PTR_NUM      = 5;
  localparam logic [2:0]  PI_ZERO      = 3'h0;
  localparam logic [2:0]  PI_ONE_LOW   = 3'h1;
  localparam logic [2:0]  PI_ONE_SEC   = 3'h2;
  localparam logic [2:0]  PI_TWO_LOW   = 3'h3;
  localparam logic [2:0]  PI_TWO_SEC   = 3'h4;
  localparam logic [7:0]  PTR_RESET    = 8'h00;

  typedef enum logic [1:0] {TGT_NONE, TGT_GP, TGT_PTR, TGT_SFR} dmsa_tgt_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_BSET, OP_BCLR} dmsa_op_t;
  typedef enum logic {PH_IDLE, PH_MODIFY} dmsa_ph_t;

  function automatic logic is_port(input logic [7:0] off);
    is_port = (off == OFF_PORT0) || (off == OFF_PORT1) || (off == OFF_PORT2);
  endfunction : is_port

  function automatic logic is_ptr(input logic [7:0] off);
    is_ptr = (off == OFF_PTR0) || (off == OFF_PTR1L) || (off == OFF_PTR1S) ||
             (off == OFF_PTR2L) || (off == OFF_PTR2S);
  endfunction : is_ptr

endpackage : dmsa_pkg

/* File: rtl/dmsa_acc_if.sv */
// resolved access and memory port between the addressing modules
`timescale 1ns/1ns
interface dmsa_acc_if;
  logic [dmsa_pkg::ADDR_W-1:0]             addr;
  logic [dmsa_pkg::PTR_NUM-1:0][7:0]       ptr;
  dmsa_pkg::dmsa_tgt_t                     kind;
  logic [2:0]                              pidx;
  logic [dmsa_pkg::GP_IDX_W-1:0]           gidx;
  logic [dmsa_pkg::ADDR_W-1:0]             eff;
  logic                                    en;
  logic                                    we;
  logic [dmsa_pkg::GP_IDX_W-1:0]           ram_idx;
  logic [7:0]                              wdata;
  logic [7:0]                              rdata;

  modport ctl (output addr, ptr, en, we, ram_idx, wdata, input kind, pidx, gidx, eff, rdata);
  modport gen (input addr, ptr, output kind, pidx, gidx, eff);
  modport mem (input en, we, ram_idx, wdata, output rdata);
endinterface : dmsa_acc_if

/* File: rtl/dmsa_addr_gen.sv */
// resolves a core address, direct or through a pointer, to its target
`timescale 1ns/1ns
module dmsa_addr_gen (
  dmsa_acc_if.gen a
);
  logic [7:0] sec;
  logic [7:0] off;

  always_comb
  begin
    sec    = 8'(a.addr[dmsa_pkg::SEC_LSB +: dmsa_pkg::SEC_W]);
    off    = a.addr[dmsa_pkg::OFF_W-1:0];
    a.pidx = dmsa_pkg::PI_ZERO;
    // no bank pointer: port 0 stays in sector 0, ports 1 and 2 take the sector from their pointer bytes
    if (sec == dmsa_pkg::SECTOR_ZERO && off == dmsa_pkg::OFF_PORT0)
    begin
      sec = dmsa_pkg::SECTOR_ZERO;
      off = a.ptr[dmsa_pkg::PI_ZERO];
    end
    else if (sec == dmsa_pkg::SECTOR_ZERO && off == dmsa_pkg::OFF_PORT1)
    begin
      sec = a.ptr[dmsa_pkg::PI_ONE_SEC];
      off = a.ptr[dmsa_pkg::PI_ONE_LOW];
    end
    else if (sec == dmsa_pkg::SECTOR_ZERO && off == dmsa_pkg::OFF_PORT2)
    begin
      sec = a.ptr[dmsa_pkg::PI_TWO_SEC];
      off = a.ptr[dmsa_pkg::PI_TWO_LOW];
    end
    // direct addresses carry sector in the upper bits
    a.eff  = {sec[dmsa_pkg::SEC_W-1:0], off};
    a.gidx = {sec[dmsa_pkg::SEC_W-1:0], off[dmsa_pkg::GP_OFF_W-1:0]};
    if (off >= dmsa_pkg::GP_BASE)
      a.kind = (sec < dmsa_pkg::GP_SECTORS) ? dmsa_pkg::TGT_GP : dmsa_pkg::TGT_NONE;
    else if (sec == dmsa_pkg::SECTOR_ZERO && dmsa_pkg::is_port(off))
      a.kind = dmsa_pkg::TGT_NONE;
    else if (sec == dmsa_pkg::SECTOR_ZERO && dmsa_pkg::is_ptr(off))
      a.kind = dmsa_pkg::TGT_PTR;
    else if (sec < dmsa_pkg::SFR_SECTORS)
      a.kind = dmsa_pkg::TGT_SFR;
    else
      a.kind = dmsa_pkg::TGT_NONE;
    unique case (off)
      dmsa_pkg::OFF_PTR1L: a.pidx = dmsa_pkg::PI_ONE_LOW;
      dmsa_pkg::OFF_PTR1S: a.pidx = dmsa_pkg::PI_ONE_SEC;
      dmsa_pkg::OFF_PTR2L: a.pidx = dmsa_pkg::PI_TWO_LOW;
      dmsa_pkg::OFF_PTR2S: a.pidx = dmsa_pkg::PI_TWO_SEC;
      default:             a.pidx = dmsa_pkg::PI_ZERO;
    endcase
  end
endmodule : dmsa_addr_gen

/* File: rtl/dmsa_gpram.sv */
// general purpose byte memory, registered read data
`timescale 1ns/1ns
module dmsa_gpram (
  input wire logic clk,
  dmsa_acc_if.mem  m
);
  logic [7:0] mem_q [dmsa_pkg::GP_DEPTH];
  logic [7:0] rdata_q;

  // read-before-write: a bit update sees the old byte
  always_ff @(posedge clk)
  begin
    if (m.en)
    begin
      if (m.we)
        mem_q[m.ram_idx] <= m.wdata;
      rdata_q <= mem_q[m.ram_idx];
    end
  end

  assign m.rdata = rdata_q;
endmodule : dmsa_gpram

/* File: rtl/dmsa_top.sv */
// data memory sector addressing: pointers, indirect ports, routing
`timescale 1ns/1ns
module dmsa_top (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          acc_valid,
  output logic                               acc_ready,
  input  wire dmsa_pkg::dmsa_op_t            acc_op,
  input  wire logic [dmsa_pkg::ADDR_W-1:0]   acc_addr,
  input  wire logic [2:0]                    acc_bit,
  input  wire logic [7:0]                    acc_wdata,
  output logic                               rd_valid,
  output logic [7:0]                         rd_data,
  output logic                               sfr_re,
  output logic                               sfr_we,
  output logic [dmsa_pkg::ADDR_W-1:0]        sfr_addr,
  output logic [7:0]                         sfr_wdata,
  input  wire logic [7:0]                    sfr_rdata,
  input  wire logic                          sfr_present,
  input  wire logic                          sfr_ro
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [dmsa_pkg::PTR_NUM-1:0][7:0] ptr;
    dmsa_pkg::dmsa_ph_t                ph;
    dmsa_pkg::dmsa_tgt_t               kind;
    logic [2:0]                        pidx;
    logic [dmsa_pkg::GP_IDX_W-1:0]     gidx;
    logic [dmsa_pkg::ADDR_W-1:0]       eff;
    logic                              bset;
    logic [2:0]                        bitn;
    logic                              src_ram;
    logic                              rvalid;
    logic [7:0]                        rdata;
  } dmsa_st_t;

  dmsa_st_t   q;
  dmsa_st_t   d;
  logic       take;
  logic       is_wr;
  logic       is_bit;
  logic       sfr_ok;
  logic [7:0] old_byte;
  logic [7:0] mod_byte;

  dmsa_acc_if acc ();

  dmsa_addr_gen u_gen (
    .a (acc.gen)
  );

  dmsa_gpram u_ram (
    .clk (clk),
    .m   (acc.mem)
  );

  function automatic logic [7:0] bit_apply(input logic [7:0] b, input logic [2:0] n, input logic s);
    logic [7:0] r;
    r    = b;
    r[n] = s;
    return r;
  endfunction : bit_apply

  // ****************************************
  // access control
  // ****************************************
  assign acc_ready = (q.ph == dmsa_pkg::PH_IDLE);
  assign take      = acc_valid && acc_ready;
  assign is_wr     = (acc_op == dmsa_pkg::OP_WRITE);
  assign is_bit    = (acc_op == dmsa_pkg::OP_BSET) || (acc_op == dmsa_pkg::OP_BCLR);
  // read-only and absent registers never see a write strobe
  assign sfr_ok    = sfr_present && !sfr_ro;
  assign old_byte  = q.src_ram ? acc.rdata : q.rdata;
  assign mod_byte  = bit_apply(old_byte, q.bitn, q.bset);

  always_comb
  begin
    d           = q;
    d.rvalid    = 1'b0;
    acc.addr    = acc_addr;
    acc.ptr     = q.ptr;
    acc.en      = 1'b0;
    acc.we      = 1'b0;
    acc.ram_idx = acc.gidx;
    acc.wdata   = acc_wdata;
    sfr_re      = 1'b0;
    sfr_we      = 1'b0;
    sfr_addr    = acc.eff;
    sfr_wdata   = acc_wdata;
    unique case (q.ph)
      dmsa_pkg::PH_IDLE:
      begin
        if (take)
        begin
          d.kind    = acc.kind;
          d.pidx    = acc.pidx;
          d.gidx    = acc.gidx;
          d.eff     = acc.eff;
          d.bset    = (acc_op == dmsa_pkg::OP_BSET);
          d.bitn    = acc_bit;
          d.src_ram = (acc.kind == dmsa_pkg::TGT_GP);
          d.rdata   = dmsa_pkg::ZERO_BYTE;
          unique case (acc.kind)
            dmsa_pkg::TGT_GP:
            begin
              acc.en = 1'b1;
              acc.we = is_wr;
            end
            dmsa_pkg::TGT_PTR:
            begin
              d.rdata = q.ptr[acc.pidx];
              if (is_wr)
                d.ptr[acc.pidx] = acc_wdata;
            end
            dmsa_pkg::TGT_SFR:
            begin
              sfr_re = !is_wr;
              sfr_we = is_wr && sfr_ok;
              if (sfr_present)
                d.rdata = sfr_rdata;
            end
            dmsa_pkg::TGT_NONE:
            begin
              // writes to ports or unused space are dropped here
            end
          endcase
          d.rvalid = (acc_op == dmsa_pkg::OP_READ);
          if (is_bit)
            d.ph = dmsa_pkg::PH_MODIFY;
        end
      end
      dmsa_pkg::PH_MODIFY:
      begin
        // second cycle of a bit update writes back the modified byte
        d.ph        = dmsa_pkg::PH_IDLE;
        acc.ram_idx = q.gidx;
        acc.wdata   = mod_byte;
        sfr_addr    = q.eff;
        sfr_wdata   = mod_byte;
        unique case (q.kind)
          dmsa_pkg::TGT_GP:
          begin
            acc.en = 1'b1;
            acc.we = 1'b1;
          end
          dmsa_pkg::TGT_PTR:  d.ptr[q.pidx] = mod_byte;
          dmsa_pkg::TGT_SFR:  sfr_we = sfr_ok;
          dmsa_pkg::TGT_NONE: d.ph = dmsa_pkg::PH_IDLE;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q         <= '0;
      q.ptr     <= {dmsa_pkg::PTR_NUM{dmsa_pkg::PTR_RESET}};
      q.ph      <= dmsa_pkg::PH_IDLE;
      q.kind    <= dmsa_pkg::TGT_NONE;
    end
    else
      q <= d;
  end

  // ****************************************
  // read answer
  // ****************************************
  // memory data leaves its own output flop, no extra cycle spent
  assign rd_valid = q.rvalid;
  assign rd_data  = q.src_ram ? acc.rdata : q.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_one_cycle: assert property (take && acc_op == dmsa_pkg::OP_READ |=> rd_valid)
    else $error("read answer not one cycle after request");

  a_no_stray_answer: assert property (!(take && acc_op == dmsa_pkg::OP_READ) |=> !rd_valid)
    else $error("read answer without a read request");

  a_port_read_zero: assert property (take && acc_op == dmsa_pkg::OP_READ && acc.kind == dmsa_pkg::TGT_NONE
    |=> rd_valid && rd_data == dmsa_pkg::ZERO_BYTE)
    else $error("unused or port location did not read zero");

  a_ptr_write_next: assert property (take && is_wr && acc.kind == dmsa_pkg::TGT_PTR
    |=> q.ptr[$past(acc.pidx)] == $past(acc_wdata))
    else $error("pointer write not visible on the next access");

  a_ro_write_block: assert property (sfr_we |-> sfr_present && !sfr_ro)
    else $error("write strobe reached a read-only register");

  a_port0_sector0: assert property (take && acc_addr == {{dmsa_pkg::SEC_W{1'b0}}, dmsa_pkg::OFF_PORT0}
    |-> acc.eff == {{dmsa_pkg::SEC_W{1'b0}}, q.ptr[dmsa_pkg::PI_ZERO]})
    else $error("port zero left sector 0");

  a_port1_sector: assert property (take && acc_addr == {{dmsa_pkg::SEC_W{1'b0}}, dmsa_pkg::OFF_PORT1}
    |-> acc.eff == {q.ptr[dmsa_pkg::PI_ONE_SEC][dmsa_pkg::SEC_W-1:0], q.ptr[dmsa_pkg::PI_ONE_LOW]})
    else $error("port one did not follow its pointer pair");

  a_bit_two_cycles: assert property (take && is_bit |=> !acc_ready ##1 acc_ready)
    else $error("bit update did not take exactly two cycles");

  a_ram_sector_map: assert property (acc.en |-> ((q.ph == dmsa_pkg::PH_MODIFY) ? acc.ram_idx == q.gidx
    : acc.eff[dmsa_pkg::OFF_W-1]
      && acc.ram_idx == {acc.eff[dmsa_pkg::SEC_LSB +: dmsa_pkg::SEC_W], acc.eff[dmsa_pkg::GP_OFF_W-1:0]}))
    else $error("memory index outside the general area map");

  a_no_recursion: assert property (take && acc_addr[dmsa_pkg::SEC_LSB +: dmsa_pkg::SEC_W] == '0
    && dmsa_pkg::is_port(acc_addr[dmsa_pkg::OFF_W-1:0]) && acc.eff[dmsa_pkg::SEC_LSB +: dmsa_pkg::SEC_W] == '0
    && dmsa_pkg::is_port(acc.eff[dmsa_pkg::OFF_W-1:0]) |-> acc.kind == dmsa_pkg::TGT_NONE && !acc.we)
    else $error("indirect access recursed through a port");

  // ****************************************
  // checks: routing
  // ****************************************
  a_direct_passes: assert property (take
    && !(acc_addr[dmsa_pkg::SEC_LSB +: dmsa_pkg::SEC_W] == '0 && dmsa_pkg::is_port(acc_addr[dmsa_pkg::OFF_W-1:0]))
    |-> acc.eff == acc_addr)
    else $error("direct address was altered");

  a_port2_sector: assert property (take && acc_addr == {{dmsa_pkg::SEC_W{1'b0}}, dmsa_pkg::OFF_PORT2}
    |-> acc.eff == {q.ptr[dmsa_pkg::PI_TWO_SEC][dmsa_pkg::SEC_W-1:0], q.ptr[dmsa_pkg::PI_TWO_LOW]})
    else $error("port two did not follow its pointer pair");

  a_far_sector_none: assert property (take && acc_addr == {{dmsa_pkg::SEC_W{1'b0}}, dmsa_pkg::OFF_PORT2}
    && q.ptr[dmsa_pkg::PI_TWO_SEC] >= dmsa_pkg::GP_SECTORS |-> acc.kind == dmsa_pkg::TGT_NONE)
    else $error("pointer sector beyond the map was not treated as unused");

  a_far_special_none: assert property (take && acc_addr == {{dmsa_pkg::SEC_W{1'b0}}, dmsa_pkg::OFF_PORT1}
    && q.ptr[dmsa_pkg::PI_ONE_SEC] >= dmsa_pkg::SFR_SECTORS && !q.ptr[dmsa_pkg::PI_ONE_LOW][dmsa_pkg::OFF_W-1]
    |-> acc.kind == dmsa_pkg::TGT_NONE)
    else $error("special location beyond the map was not treated as unused");

  a_none_quiet: assert property (take && acc.kind == dmsa_pkg::TGT_NONE
    |-> !acc.en && !sfr_re && !sfr_we)
    else $error("access to unused space reached a store");

  a_gp_enable: assert property (take && acc.kind == dmsa_pkg::TGT_GP
    |-> acc.en && acc.we == is_wr && acc.wdata == acc_wdata)
    else $error("general memory access not passed to the store");

  a_gp_read_answer: assert property (take && acc_op == dmsa_pkg::OP_READ && acc.kind == dmsa_pkg::TGT_GP
    |=> rd_valid && q.src_ram)
    else $error("general memory read not answered from the store");

  a_read_no_store: assert property (take && !is_wr |-> !acc.we)
    else $error("read or first bit cycle wrote the store");

  // ****************************************
  // checks: pointers
  // ****************************************
  a_ptr_read_value: assert property (take && acc_op == dmsa_pkg::OP_READ && acc.kind == dmsa_pkg::TGT_PTR
    |=> rd_data == $past(q.ptr[acc.pidx]))
    else $error("pointer read returned another value");

  a_ptr_hold_idle: assert property (q.ph == dmsa_pkg::PH_IDLE && !take |=> $stable(q.ptr))
    else $error("pointer changed without an access");

  a_ptr_other_target: assert property (take && acc.kind != dmsa_pkg::TGT_PTR |=> $stable(q.ptr))
    else $error("pointer changed by an access elsewhere");

  a_ptr_bit_write: assert property (q.ph == dmsa_pkg::PH_MODIFY && q.kind == dmsa_pkg::TGT_PTR
    |=> q.ptr[$past(q.pidx)] == $past(mod_byte))
    else $error("pointer bit update lost");

  // ****************************************
  // checks: special registers
  // ****************************************
  a_sfr_read_strobe: assert property (sfr_re |-> take && acc.kind == dmsa_pkg::TGT_SFR && !is_wr)
    else $error("special register read strobe without a read");

  a_sfr_write_pass: assert property (take && is_wr && acc.kind == dmsa_pkg::TGT_SFR
    && sfr_present && !sfr_ro |-> sfr_we && sfr_addr == acc.eff && sfr_wdata == acc_wdata)
    else $error("write to a writable special register dropped");

  a_sfr_read_value: assert property (take && !is_wr && acc.kind == dmsa_pkg::TGT_SFR && sfr_present
    |=> q.rdata == $past(sfr_rdata))
    else $error("special register read data not kept");

  a_sfr_absent_zero: assert property (take && acc_op == dmsa_pkg::OP_READ && acc.kind == dmsa_pkg::TGT_SFR
    && !sfr_present |=> rd_valid && rd_data == dmsa_pkg::ZERO_BYTE)
    else $error("absent special register did not read zero");

  a_sfr_low_half: assert property (sfr_re || sfr_we |-> !sfr_addr[dmsa_pkg::OFF_W-1])
    else $error("special register strobe in the general half");

  a_sfr_sector_range: assert property (sfr_re || sfr_we
    |-> sfr_addr[dmsa_pkg::SEC_LSB +: dmsa_pkg::SEC_W] < dmsa_pkg::SFR_SECTORS)
    else $error("special register strobe outside the special sectors");

  a_idle_quiet: assert property (q.ph == dmsa_pkg::PH_IDLE && !take
    |-> !acc.en && !sfr_re && !sfr_we)
    else $error("store strobed without an access");

  // ****************************************
  // checks: bit updates
  // ****************************************
  a_modify_one_cycle: assert property (q.ph == dmsa_pkg::PH_MODIFY |=> q.ph == dmsa_pkg::PH_IDLE)
    else $error("bit update stayed in its second cycle");

  a_modify_blocks: assert property (q.ph == dmsa_pkg::PH_MODIFY |-> !acc_ready)
    else $error("request accepted during a bit update");

  a_bit_value: assert property (q.ph == dmsa_pkg::PH_MODIFY
    |-> acc.wdata[q.bitn] == q.bset && sfr_wdata == acc.wdata
    && ((acc.wdata ^ old_byte) & ~(8'h01 << q.bitn)) == 8'h00)
    else $error("bit update touched the wrong bit");

  a_bit_gp_write: assert property (q.ph == dmsa_pkg::PH_MODIFY && q.kind == dmsa_pkg::TGT_GP
    |-> acc.en && acc.we && acc.ram_idx == q.gidx)
    else $error("bit update not written back to the store");

  a_bit_sfr_write: assert property (q.ph == dmsa_pkg::PH_MODIFY && q.kind == dmsa_pkg::TGT_SFR
    |-> sfr_addr == q.eff && sfr_we == (sfr_present && !sfr_ro) && !sfr_re)
    else $error("bit update on a special register mishandled");

  a_bit_none_quiet: assert property (q.ph == dmsa_pkg::PH_MODIFY && q.kind == dmsa_pkg::TGT_NONE
    |-> !acc.en && !sfr_we)
    else $error("bit update on unused space reached a store");

  a_write_silent: assert property (take && acc_op == dmsa_pkg::OP_WRITE |=> !rd_valid)
    else $error("write produced a read answer");

endmodule : dmsa_top

/* File: tb/dmsa_sfr_model.sv */
// outside special register bank model facing the addressing block
`timescale 1ns/1ns
module dmsa_sfr_model (
  input  wire logic                        clk,
  input  wire logic                        sfr_re,
  input  wire logic                        sfr_we,
  input  wire logic [dmsa_pkg::ADDR_W-1:0] sfr_addr,
  input  wire logic [7:0]                  sfr_wdata,
  output logic      [7:0]                  sfr_rdata,
  output logic                             sfr_present,
  output logic                             sfr_ro
);
  // ****
  // storage, holes and a read-only byte at offset 0a in each sector
  // ****
  logic [7:0] regs [256];
  logic [7:0] idx;

  assign idx         = {sfr_addr[8], sfr_addr[6:0]};
  assign sfr_present = !(sfr_addr[7:0] inside {8'h0b, 8'h71});
  assign sfr_ro      = (sfr_addr[7:0] == 8'h0a);
  // junk when not strobed, so a missed strobe or a hole shows up
  assign sfr_rdata   = (sfr_re && sfr_present) ? regs[idx] : 8'ha5;

  initial foreach (regs[i]) regs[i] = 8'h00;

  always @(posedge clk)
    if (sfr_we)
      regs[idx] <= sfr_wdata;
endmodule : dmsa_sfr_model

/* File: tb/data_memory_sector_addressing_bench.sv */
// self-checking bench for the data memory sector addressing block
`timescale 1ns/1ns
module data_memory_sector_addressing_bench;
  logic                        clk, rst, acc_valid, acc_ready, rd_valid, rdy_s;
  logic                        sfr_re, sfr_we, sfr_present, sfr_ro;
  dmsa_pkg::dmsa_op_t          acc_op;
  logic [dmsa_pkg::ADDR_W-1:0] acc_addr, sfr_addr;
  logic [2:0]                  acc_bit;
  logic [7:0]                  acc_wdata, rd_data, sfr_wdata, sfr_rdata;
  int                          miscompares, n_tests;

  dmsa_top i_dut (.clk(clk), .rst(rst), .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_op(acc_op),
    .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .sfr_re(sfr_re), .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_present(sfr_present), .sfr_ro(sfr_ro));
  dmsa_sfr_model i_sfr (.clk(clk), .sfr_re(sfr_re), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_present(sfr_present), .sfr_ro(sfr_ro));

  // ****
  // bus tasks
  // ****
  // ready seen mid-cycle, so the take edge is known without a race
  always @(negedge clk) rdy_s <= acc_ready;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // leaves valid high; the next call or rd takes it over
  task automatic acc(input dmsa_pkg::dmsa_op_t op, input logic [9:0] a, input logic [2:0] b, input logic [7:0] d);
    acc_valid <= 1'b1;
    acc_op    <= op;
    acc_addr  <= a;
    acc_bit   <= b;
    acc_wdata <= d;
    do @(posedge clk); while (rdy_s !== 1'b1);
  endtask : acc

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    acc(dmsa_pkg::OP_WRITE, a, 3'h0, d);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    acc(dmsa_pkg::OP_READ, a, 3'h0, 8'h00);
    acc_valid <= 1'b0;
    @(negedge clk);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, e);
    @(posedge clk);
  endtask : rd

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd(10'h001, 8'h00);
    rd(10'h003, 8'h00);
    rd(10'h004, 8'h00);
    rd(10'h00d, 8'h00);
    rd(10'h00e, 8'h00);
    rd(10'h000, 8'h00);
  endtask : t_reset

  task automatic t_direct;
    for (int s = 0; s < 4; s++)
    begin
      wr({s[1:0], 8'h80}, 8'h10 + 8'(s));
      wr({s[1:0], 8'hff}, 8'h20 + 8'(s));
    end
    for (int s = 0; s < 4; s++)
    begin
      rd({s[1:0], 8'h80}, 8'h10 + 8'(s));
      rd({s[1:0], 8'hff}, 8'h20 + 8'(s));
    end
    acc(dmsa_pkg::OP_BSET, 10'h380, 3'h7, 8'h00);
    @(negedge clk);
    chk({7'h00, acc_ready}, 8'h00);
    @(posedge clk);
    acc(dmsa_pkg::OP_BCLR, 10'h380, 3'h0, 8'h00);
    rd(10'h380, 8'h92);
    rd(10'h205, 8'h00);
    wr(10'h305, 8'h44);
    rd(10'h305, 8'h00);
  endtask : t_direct

  task automatic t_ptr;
    wr(10'h004, 8'h02);
    wr(10'h003, 8'h90);
    wr(10'h002, 8'h77);
    rd(10'h290, 8'h77);
    wr(10'h00e, 8'h03);
    wr(10'h00d, 8'hff);
    rd(10'h00c, 8'h23);
    wr(10'h00e, 8'h04);
    rd(10'h00c, 8'h00);
    rd(10'h003, 8'h90);
    rd(10'h004, 8'h02);
    acc(dmsa_pkg::OP_BSET, 10'h001, 3'h7, 8'h00);
    rd(10'h001, 8'h80);
    rd(10'h000, 8'h10);
    wr(10'h000, 8'h5c);
    rd(10'h080, 8'h5c);
    rd(10'h280, 8'h12);
  endtask : t_ptr

  task automatic t_ports;
    rd(10'h002, 8'h77);
    wr(10'h001, 8'h02);
    rd(10'h000, 8'h00);
    wr(10'h004, 8'h00);
    wr(10'h003, 8'h0c);
    rd(10'h002, 8'h00);
    wr(10'h002, 8'h99);
    rd(10'h00d, 8'hff);
    rd(10'h00e, 8'h04);
    rd(10'h3ff, 8'h23);
  endtask : t_ports

  task automatic t_sfr;
    wr(10'h005, 8'h5a);
    rd(10'h005, 8'h5a);
    wr(10'h00a, 8'hff);
    rd(10'h00a, 8'h00);
    rd(10'h00b, 8'h00);
    rd(10'h171, 8'h00);
    wr(10'h100, 8'h33);
    rd(10'h100, 8'h33);
    acc(dmsa_pkg::OP_BSET, 10'h005, 3'h0, 8'h00);
    rd(10'h005, 8'h5b);
  endtask : t_sfr

  // ****
  // run control
  // ****
  task automatic print_verdict;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    rst       = 1'b1;
    acc_valid = 1'b0;
    acc_op    = dmsa_pkg::OP_READ;
    acc_addr  = 10'h000;
    acc_bit   = 3'h0;
    acc_wdata = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_direct();
    t_ptr();
    t_ports();
    t_sfr();
    print_verdict();
  end

  // whole run is about a hundred cycles; this is far beyond it
  initial
  begin
    #40000;
    miscompares++;
    print_verdict();
  end
endmodule : data_memory_sector_addressing_bench
